// [verilog/logic_group_io_and_enable.sv]
// Top: one logic group with eight blocks, router, shared enable, I/O cells.
// Contract
// - Term 12, when unused by logic, may clock or reset its block.
// - Four-term bypass outputs never use term 12.
// - Term 12 feeds four-input OR in xor mode, else five-input OR.
// - Dedicated inputs reach only this group's eight blocks.
// - Dedicated inputs are unregistered and pass combinationally.
// - Each block offers an enable term; one of eight is selected.
// - The selected enable drives all sixteen cells together.
// - Only one group enable exists; other enable terms stay logic. Here term 19 feeds no block logic; or7 takes terms 13 to 18 only.
// - Every cell input goes straight to the global interconnect.
// - Router sends each block output to one of four cells. Here each output of block b reaches only cells 2b and 2b+1.
// - A bypass links fixed block outputs to fixed cells.
// - Each cell picks routed or bypass source and output polarity.
// - Cell enable: always on, always off, or group enable, with polarity.
// - Global reset from low-active pin reaches every register.
// - Each cell picks one of two io clocks for its storage.
// - Cell storage is either transparent latch or edge flip-flop.
// - Cells act as input, output, three-state output or bidirectional.
// - Reset forces every affected register to zero. Here oe_n_reg resets to all ones instead, so pins are not driven.
// - Block reset is global reset ORed with term reset.
`timescale 1ns/10ps
`default_nettype none
module logic_group_io_and_enable
    import group_pkg::*;
(
    input  wire logic                  aclk,          // Fabric clock
    input  wire logic                  aresetn,       // Sync reset, low
    input  wire axil_req_t             axil_req,      // AXI4-Lite requests
    output axil_rsp_t                  axil_rsp,      // AXI4-Lite answers
    input  wire logic [NUM_BLOCKS-1:0][NUM_TERMS-1:0]
                                       block_terms,   // Terms per block
    output logic [NUM_DED-1:0]         ded_to_blocks, // Dedicated inputs out
    input  wire logic [NUM_DED-1:0]    ded_in,        // Dedicated pins
    input  wire logic                  io_clock_a,    // I/O clock line a
    input  wire logic                  io_clock_b,    // I/O clock line b
    input  wire logic [NUM_CELLS-1:0]  pin_in,        // Pin level in
    output logic [NUM_CELLS-1:0]       pin_out,       // Pin drive value
    output logic [NUM_CELLS-1:0]       pin_oe_n,      // Pin enable, low drives
    output logic [NUM_CELLS-1:0]       global_in,     // Cell inputs to fabric
    output logic [NUM_CELLS-1:0]       stored_in,     // Latched/registered in
    output logic [NUM_BLOCKS*4-1:0]    block_outs     // Block outputs
);
    logic [NUM_BLOCKS-1:0][31:0] blk_cfg_reg;
    logic [NUM_CELLS-1:0][31:0]  cell_cfg_reg;
    logic [2:0]                  group_reg;
    logic [NUM_BLOCKS-1:0]       enable_cand;
    logic                        group_oe;
    logic                        global_rst;
    logic [NUM_CELLS-1:0]        clka_reg;
    logic [NUM_CELLS-1:0]        clkb_reg;
    logic [NUM_CELLS-1:0]        store_reg;
    logic [NUM_CELLS-1:0]        out_reg;
    logic [NUM_CELLS-1:0]        oe_n_reg;
    logic [NUM_CELLS-1:0]        cell_d;
    logic [NUM_CELLS-1:0]        cell_en;

    assign global_rst = ~aresetn;

    // Dedicated pins go to this group's blocks only, unregistered
    assign ded_to_blocks = ded_in;

    genvar b;
    generate
        for (b = 0; b < NUM_BLOCKS; b++) begin : g_blk
            logic [NUM_TERMS-1:0] t;
            assign t = block_terms[b];
            logic_block u_blk (
                .aclk        (aclk),
                .global_rst  (global_rst),
                .terms       (t),
                .cfg         (blk_cfg_reg[b]),
                .outs        (block_outs[b*4 +: 4]),
                .enable_term (enable_cand[b])
            );
        end
    endgenerate

    // One enable chosen from eight candidates
    assign group_oe = enable_cand[group_reg];

    // I/O cells
    genvar c;
    generate
        for (c = 0; c < NUM_CELLS; c++) begin : g_cell
            logic [31:0] cf;
            logic [1:0]  route;
            logic [4:0]  src_idx;
            logic        routed;
            logic        bypass;
            logic        edge_hit;
            logic        clk_lvl;
            assign cf = cell_cfg_reg[c];
            assign route = cf[CELL_ROUTE_POS +: 2];
            // Cell c is reachable from four block outputs, spread by route
            assign src_idx = 5'((c / CELLS_PER_BLOCK) * 4)
                           + 5'({3'h0, route});
            assign routed = block_outs[src_idx];
            assign bypass = block_outs[5'(c * 2)];
            always_comb begin
                cell_d[c] = (cf[CELL_SRC_POS] ? bypass : routed)
                          ^ cf[CELL_POL_POS];
                case (cf[CELL_OEM_POS +: 2])
                    OE_ON:    cell_en[c] = 1'b1;
                    OE_OFF:   cell_en[c] = 1'b0;
                    OE_GROUP: cell_en[c] = group_oe ^ cf[CELL_OEP_POS];
                    default:  cell_en[c] = 1'b0;
                endcase
            end
            assign clk_lvl  = cf[CELL_CLK_POS] ? clkb_reg[c] : clka_reg[c];
            assign edge_hit = cf[CELL_CLK_POS]
                            ? (io_clock_b & ~clkb_reg[c])
                            : (io_clock_a & ~clka_reg[c]);
            always_ff @(posedge aclk) begin
                if (global_rst) begin
                    store_reg[c] <= 1'b0;
                end else if (cf[CELL_LAT_POS] ? clk_lvl : edge_hit) begin
                    store_reg[c] <= pin_in[c];
                end
            end
        end
    endgenerate

    // I/O clock lines are sampled as synchronous levels
    always_ff @(posedge aclk) begin
        if (global_rst) begin
            clka_reg <= '0;
            clkb_reg <= '0;
        end else begin
            clka_reg <= {NUM_CELLS{io_clock_a}};
            clkb_reg <= {NUM_CELLS{io_clock_b}};
        end
    end

    // Pin drive registered; disabled output makes a plain input
    always_ff @(posedge aclk) begin
        if (global_rst) begin
            out_reg  <= '0;
            oe_n_reg <= '1;
        end else begin
            out_reg  <= cell_d;
            oe_n_reg <= ~cell_en;
        end
    end
    assign pin_out   = out_reg;
    assign pin_oe_n  = oe_n_reg;
    assign global_in = pin_in;
    assign stored_in = store_reg;

    // AXI4-Lite slave, one write and one read at a time
    logic        aw_have;
    logic        w_have;
    logic [11:0] aw_addr_reg;
    logic [31:0] w_data_reg;
    logic [3:0]  w_strb_reg;
    logic        bvalid_reg;
    logic [1:0]  bresp_reg;
    logic        rvalid_reg;
    logic [31:0] rdata_reg;
    logic [1:0]  rresp_reg;
    logic        do_write;
    logic [31:0] rd_val;
    logic        rd_ok;

    assign axil_rsp.awready = ~aw_have & ~bvalid_reg;
    assign axil_rsp.wready  = ~w_have & ~bvalid_reg;
    assign axil_rsp.bvalid  = bvalid_reg;
    assign axil_rsp.bresp   = bresp_reg;
    assign axil_rsp.arready = ~rvalid_reg;
    assign axil_rsp.rvalid  = rvalid_reg;
    assign axil_rsp.rdata   = rdata_reg;
    assign axil_rsp.rresp   = rresp_reg;
    assign do_write = aw_have & w_have & ~bvalid_reg;

    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] nw,
                                          input logic [3:0]  st);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (st[i]) begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return r;
    endfunction

    always_ff @(posedge aclk) begin
        if (global_rst) begin
            aw_have     <= 1'b0;
            w_have      <= 1'b0;
            aw_addr_reg <= 12'h000;
            w_data_reg  <= 32'h0000_0000;
            w_strb_reg  <= 4'h0;
        end else begin
            if (axil_req.awvalid && axil_rsp.awready) begin
                aw_have     <= 1'b1;
                aw_addr_reg <= axil_req.awaddr;
            end else if (do_write) begin
                aw_have <= 1'b0;
            end
            if (axil_req.wvalid && axil_rsp.wready) begin
                w_have     <= 1'b1;
                w_data_reg <= axil_req.wdata;
                w_strb_reg <= axil_req.wstrb;
            end else if (do_write) begin
                w_have <= 1'b0;
            end
        end
    end

    // Configuration is static once written; the fabric just follows it
    always_ff @(posedge aclk) begin
        if (global_rst) begin
            blk_cfg_reg  <= {NUM_BLOCKS{BLK_CFG_RESET}};
            cell_cfg_reg <= {NUM_CELLS{CELL_CFG_RESET}};
            group_reg    <= GROUP_RESET;
            bvalid_reg   <= 1'b0;
            bresp_reg    <= RESP_OKAY;
        end else begin
            if (do_write) begin
                bvalid_reg <= 1'b1;
                bresp_reg  <= RESP_OKAY;
                if (aw_addr_reg < ADDR_CELL_BASE && aw_addr_reg[1:0] == 2'h0) begin
                    blk_cfg_reg[aw_addr_reg[4:2]] <= merge(
                        blk_cfg_reg[aw_addr_reg[4:2]], w_data_reg, w_strb_reg);
                end else if (aw_addr_reg < ADDR_GROUP && aw_addr_reg[1:0] == 2'h0) begin
                    cell_cfg_reg[aw_addr_reg[5:2]] <= merge(
                        cell_cfg_reg[aw_addr_reg[5:2]], w_data_reg, w_strb_reg);
                end else if (aw_addr_reg == ADDR_GROUP) begin
                    if (w_strb_reg[0]) begin
                        group_reg <= w_data_reg[2:0];
                    end
                end else begin
                    bresp_reg <= RESP_SLVERR;
                end
            end else if (bvalid_reg && axil_req.bready) begin
                bvalid_reg <= 1'b0;
            end
        end
    end

    always_comb begin
        rd_ok  = 1'b1;
        rd_val = 32'h0000_0000;
        if (axil_req.araddr < ADDR_CELL_BASE && axil_req.araddr[1:0] == 2'h0) begin
            rd_val = blk_cfg_reg[axil_req.araddr[4:2]];
        end else if (axil_req.araddr < ADDR_GROUP && axil_req.araddr[1:0] == 2'h0) begin
            rd_val = cell_cfg_reg[axil_req.araddr[5:2]];
        end else if (axil_req.araddr == ADDR_GROUP) begin
            rd_val = {29'h0, group_reg};
        end else if (axil_req.araddr == ADDR_PIN_IN) begin
            rd_val = {16'h0, pin_in};
        end else if (axil_req.araddr == ADDR_STORED) begin
            rd_val = {16'h0, store_reg};
        end else if (axil_req.araddr == ADDR_OUT) begin
            rd_val = {15'h0, group_oe, out_reg};
        end else if (axil_req.araddr == ADDR_BLK_OUT) begin
            rd_val = block_outs;
        end else begin
            rd_ok = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (global_rst) begin
            rvalid_reg <= 1'b0;
            rdata_reg  <= 32'h0000_0000;
            rresp_reg  <= RESP_OKAY;
        end else begin
            if (axil_req.arvalid && axil_rsp.arready) begin
                rvalid_reg <= 1'b1;
                rdata_reg  <= rd_val;
                rresp_reg  <= rd_ok ? RESP_OKAY : RESP_SLVERR;
            end else if (rvalid_reg && axil_req.rready) begin
                rvalid_reg <= 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

// [verilog/group_pkg.sv]
// Package: constants, configuration fields and types of one logic group.
package group_pkg;
    localparam int NUM_BLOCKS      = 8;
    localparam int NUM_CELLS       = 16;
    localparam int NUM_TERMS       = 20;
    localparam int NUM_DED         = 2;
    localparam int ROUTE_CHOICES   = 4;
    localparam int TERM_CLK_RST    = 12;
    localparam int TERM_ENABLE     = 19;
    localparam int CELLS_PER_BLOCK = 2;

    // Register map, byte addresses
    localparam logic [11:0] ADDR_BLK_BASE  = 12'h000; // 8 words, step 4
    localparam logic [11:0] ADDR_CELL_BASE = 12'h040; // 16 words, step 4
    localparam logic [11:0] ADDR_GROUP     = 12'h080;
    localparam logic [11:0] ADDR_PIN_IN    = 12'h084;
    localparam logic [11:0] ADDR_STORED    = 12'h088;
    localparam logic [11:0] ADDR_OUT       = 12'h08C;
    localparam logic [11:0] ADDR_BLK_OUT   = 12'h090;

    localparam logic [31:0] BLK_CFG_RESET  = 32'h0000_0000;
    localparam logic [31:0] CELL_CFG_RESET = 32'h0000_0000;
    localparam logic [2:0]  GROUP_RESET    = 3'h0;

    // Block config field positions
    localparam int BLK_BYPASS_POS = 0;  // 4 bits, one per output
    localparam int BLK_XOR1_POS   = 4;
    localparam int BLK_T12_POS    = 5;  // 2 bits
    localparam int BLK_REG_POS    = 7;  // 4 bits
    localparam int BLK_FIVE_POS   = 11; // 2 bits
    // Cell config field positions
    localparam int CELL_ROUTE_POS = 0;  // 2 bits
    localparam int CELL_SRC_POS   = 2;
    localparam int CELL_POL_POS   = 3;
    localparam int CELL_OEM_POS   = 4;  // 2 bits
    localparam int CELL_OEP_POS   = 6;
    localparam int CELL_CLK_POS   = 7;
    localparam int CELL_LAT_POS   = 8;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        T12_LOGIC = 2'h0,
        T12_CLOCK = 2'h1,
        T12_RESET = 2'h2
    } term12_use_t;

    typedef enum logic [1:0] {
        OE_ON     = 2'h0,
        OE_OFF    = 2'h1,
        OE_GROUP  = 2'h2
    } oe_mode_t;

    typedef struct packed {
        logic [NUM_TERMS-1:0] terms;   // Product terms from the AND array
    } block_terms_t;

    typedef struct packed {
        logic        awvalid;
        logic [11:0] awaddr;
        logic        wvalid;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        bready;
        logic        arvalid;
        logic [11:0] araddr;
        logic        rready;
    } axil_req_t;

    typedef struct packed {
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } axil_rsp_t;
endpackage

// [verilog/logic_block.sv]
// One logic block: term sharing, four output registers and control terms.
`timescale 1ns/10ps
`default_nettype none
module logic_block
    import group_pkg::*;
(
    input  wire logic                 aclk,        // Fabric clock
    input  wire logic                 global_rst,  // Group reset, active high
    input  wire logic [NUM_TERMS-1:0] terms,       // Product terms
    input  wire logic [31:0]          cfg,         // Block configuration
    output logic [3:0]                outs,        // Block outputs
    output logic                      enable_term  // Output-enable candidate
);
    logic [3:0]  comb_out;
    logic [3:0]  q_reg;
    logic [1:0]  t12_use;
    logic        t12_logic;
    logic        t12_clk_reg;
    logic        t12_rise;
    logic        local_rst;
    logic        or4a;
    logic        or4b;
    logic        or5;
    logic        or7;
    logic [1:0]  five_sel;
    logic [3:0]  std_out;

    assign t12_use   = cfg[BLK_T12_POS +: 2];
    assign t12_logic = (t12_use == T12_LOGIC);
    assign five_sel  = cfg[BLK_FIVE_POS +: 2];
    // Term 12 joins the four-input gate in xor mode, else the five-input one
    assign or4a = |terms[3:0];
    assign or4b = |terms[7:4]
                | (cfg[BLK_XOR1_POS] & t12_logic & terms[TERM_CLK_RST]);
    assign or5  = |terms[11:8]
                | (~cfg[BLK_XOR1_POS] & t12_logic & terms[TERM_CLK_RST]);
    assign or7  = |terms[18:13];

    always_comb begin
        std_out    = {or7, or5, or4b, or4a};
        std_out[1] = cfg[BLK_XOR1_POS] ? (or4b ^ terms[8]) : or4b;
        // The five-input gate may be steered to any output
        std_out[five_sel] = std_out[five_sel] | or5;
    end

    // Bypass uses four dedicated terms per output; term 12 never enters
    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_out
            logic [3:0] bp_terms;
            always_comb begin
                bp_terms = terms[g*4 +: 4];
                if (g == 3) begin
                    bp_terms = {terms[16], terms[15], terms[14], terms[13]};
                end
            end
            assign comb_out[g] = cfg[BLK_BYPASS_POS + g]
                               ? |bp_terms : std_out[g];
            // Registers are not offered on bypassed outputs
            assign outs[g] = (cfg[BLK_REG_POS + g] & ~cfg[BLK_BYPASS_POS + g])
                           ? q_reg[g] : comb_out[g];
        end
    endgenerate

    // Term clock is modelled as a rising-edge enable on the fabric clock
    always_ff @(posedge aclk) begin
        if (global_rst) begin
            t12_clk_reg <= 1'b0;
        end else begin
            t12_clk_reg <= terms[TERM_CLK_RST];
        end
    end
    assign t12_rise  = (t12_use == T12_CLOCK)
                     ? (terms[TERM_CLK_RST] & ~t12_clk_reg) : 1'b1;
    assign local_rst = global_rst
                     | ((t12_use == T12_RESET) & terms[TERM_CLK_RST]);

    always_ff @(posedge aclk) begin
        if (local_rst) begin
            q_reg <= 4'h0;
        end else if (t12_rise) begin
            q_reg <= comb_out;
        end
    end

    assign enable_term = terms[TERM_ENABLE];
endmodule
`default_nettype wire

// [dv/logic_group_properties.sv]
// Checker: port-level properties of one logic group.
`timescale 1ns/10ps
`default_nettype none
module logic_group_checker
    import group_pkg::*;
(
    input wire logic                 aclk,          // Fabric clock
    input wire logic                 aresetn,       // Sync reset, low
    input wire axil_req_t            axil_req,      // Bus requests
    input wire axil_rsp_t            axil_rsp,      // Bus answers
    input wire logic [NUM_DED-1:0]   ded_in,        // Dedicated pins
    input wire logic [NUM_DED-1:0]   ded_to_blocks, // Dedicated to blocks
    input wire logic                 io_clock_a,    // I/O clock a
    input wire logic                 io_clock_b,    // I/O clock b
    input wire logic [NUM_CELLS-1:0] pin_in,        // Pin level
    input wire logic [NUM_CELLS-1:0] pin_out,       // Pin drive
    input wire logic [NUM_CELLS-1:0] pin_oe_n,      // Pin enable, low
    input wire logic [NUM_CELLS-1:0] global_in,     // To fabric
    input wire logic [NUM_CELLS-1:0] stored_in      // Stored inputs
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_ded_pass: assert property (ded_to_blocks == ded_in)
        else $error("dedicated inputs not passed through");
    a_global_pass: assert property (global_in == pin_in)
        else $error("cell input not sent to fabric");
    // Reset itself is the cause here, so it must not disable the check
    a_reset_clears: assert property (disable iff (1'b0)
        !aresetn |=> pin_oe_n == '1 && pin_out == '0 && stored_in == '0)
        else $error("reset did not clear cell registers");
    a_stored_quiet: assert property (
        (!io_clock_a && !io_clock_b) [*3] |=> $stable(stored_in))
        else $error("stored input changed with io clocks low");
    a_read_answer: assert property (
        axil_req.arvalid && axil_rsp.arready |=> axil_rsp.rvalid)
        else $error("read answer late");
    a_read_busy: assert property (axil_rsp.rvalid |-> !axil_rsp.arready)
        else $error("read address taken while answer pending");
    a_write_answer: assert property (axil_req.awvalid && axil_rsp.awready
        && axil_req.wvalid && axil_rsp.wready |-> ##[1:2] axil_rsp.bvalid)
        else $error("write answer late");
    a_write_busy: assert property (axil_rsp.bvalid
        |-> !axil_rsp.awready && !axil_rsp.wready)
        else $error("write taken while answer pending");
    a_bad_addr: assert property (axil_req.arvalid && axil_rsp.arready
        && axil_req.araddr == 12'hFFC |=> axil_rsp.rresp == RESP_SLVERR
        && axil_rsp.rdata == 32'h0)
        else $error("unmapped read not refused");

    c_write: cover property (axil_rsp.bvalid && axil_req.bready);
    c_drive: cover property (pin_oe_n != '1 && aresetn);
    c_store: cover property ($rose(stored_in[0]));
endmodule

bind logic_group_io_and_enable logic_group_checker u_chk (
    .aclk(aclk), .aresetn(aresetn), .axil_req(axil_req),
    .axil_rsp(axil_rsp), .ded_in(ded_in), .ded_to_blocks(ded_to_blocks),
    .io_clock_a(io_clock_a), .io_clock_b(io_clock_b), .pin_in(pin_in),
    .pin_out(pin_out), .pin_oe_n(pin_oe_n), .global_in(global_in),
    .stored_in(stored_in));
`default_nettype wire

// [dv/board_pins.sv]
// Board model: external parties and pull-ups on the sixteen pins.
`timescale 1ns/10ps
`default_nettype none
module board_pins (
    input  wire logic [15:0] pin_out,   // Device drive value
    input  wire logic [15:0] pin_oe_n,  // Device enable, low drives
    input  wire logic [15:0] board_en,  // Board drives the pin
    input  wire logic [15:0] board_val, // Board value
    output logic      [15:0] pin_lvl    // Resolved pin level
);
    // A pin nobody drives floats up through its pull-up
    always_comb begin
        for (int i = 0; i < 16; i++) begin
            if (!pin_oe_n[i]) pin_lvl[i] = pin_out[i];
            else if (board_en[i]) pin_lvl[i] = board_val[i];
            else pin_lvl[i] = 1'b1;
        end
    end
endmodule
`default_nettype wire

// [dv/test_logic_group_io_and_enable.sv]
// Testbench: bus tasks, block table, random cell traffic, storage, reset.
`timescale 1ns/10ps
`default_nettype none
module test_logic_group_io_and_enable;
    import group_pkg::*;
    logic        aclk = 0, aresetn = 0, ck_a = 0, ck_b = 0;
    axil_req_t   req = '0;
    axil_rsp_t   rsp;
    logic [7:0][19:0] terms = '0;
    logic [1:0]  ded = '0, ded_o;
    logic [15:0] lvl, p_out, p_oe_n, g_in, st_in, b_en = '0, b_val = '0;
    logic [31:0] b_outs, rd;
    logic [1:0]  resp;
    int          fails = 0, samples_checked = 0, cyc = 0;
    // Entry 7 is xor mode; the last leaves block 0 unconfigured
    logic [31:0] bc[9] = '{32'h780, 32'h7A0, 32'h7A0, 32'h780, 32'h7C0,
                           32'h8, 32'h1800, 32'h10, 32'h0};
    logic [19:0] tm[9] = '{20'hFFFFF, 20'hFEFFF, 20'h01000, 20'hFFFFF,
                           20'hFFFFF, 20'h01000, 20'h01000, 20'h01000,
                           20'h01000};
    // The five-input gate keeps output 2 and also joins its target output
    logic [3:0]  be[9] = '{4'hF, 4'hF, 4'h0, 4'hF, 4'h0, 4'h5, 4'hC, 4'h2,
                           4'h5};

    always #2 aclk = ~aclk;

    logic_group_io_and_enable u_dut (.aclk(aclk), .aresetn(aresetn),
        .axil_req(req), .axil_rsp(rsp), .block_terms(terms),
        .ded_to_blocks(ded_o), .ded_in(ded), .io_clock_a(ck_a),
        .io_clock_b(ck_b), .pin_in(lvl), .pin_out(p_out),
        .pin_oe_n(p_oe_n), .global_in(g_in), .stored_in(st_in),
        .block_outs(b_outs));
    board_pins u_board (.pin_out(p_out), .pin_oe_n(p_oe_n),
        .board_en(b_en), .board_val(b_val), .pin_lvl(lvl));

    task automatic results();
        $display("comparisons %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // Hang guard: the whole run needs well under 3000 cycles
    always @(posedge aclk) begin
        cyc++;
        if (cyc == 3000) begin
            fails++;
            results();
        end
    end
    task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fails++;
            $display("FAIL %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wt(int n);
        repeat (n) @(posedge aclk);
    endtask
    task automatic wr(logic [11:0] a, logic [31:0] d);
        req.awvalid <= 1; req.awaddr <= a; req.wvalid <= 1;
        req.wdata <= d; req.wstrb <= 4'hF; req.bready <= 1;
        do begin
            @(posedge aclk);
            if (rsp.awready) req.awvalid <= 0;
            if (rsp.wready) req.wvalid <= 0;
        end while (!rsp.bvalid);
        resp = rsp.bresp;
        req.bready <= 0;
        @(posedge aclk);
    endtask
    task automatic rd_reg(logic [11:0] a);
        req.arvalid <= 1; req.araddr <= a; req.rready <= 1;
        do begin
            @(posedge aclk);
            if (rsp.arready) req.arvalid <= 0;
        end while (!rsp.rvalid);
        rd = rsp.rdata; resp = rsp.rresp;
        req.rready <= 0;
        @(posedge aclk);
    endtask
    task automatic clk_set(logic use_b, logic val);
        if (use_b) ck_b <= val;
        else ck_a <= val;
        wt(3);
    endtask
    // Expected {pin_oe_n, pin_out} of cell c; block c/2 shows blk on
    // outputs 0 and 2, zero on outputs 1 and 3
    function automatic logic [1:0] cell_exp(logic [3:0] c, logic [8:0] cf,
                                            logic blk, logic oe_b);
        logic src, en;
        logic [1:0] idx;
        idx = cf[2] ? {c[0], 1'b0} : cf[1:0];
        src = idx[0] ? 1'b0 : blk;
        en = cf[5:4] == 0 ? 1'b1 : (cf[5:4] == 1 ? 1'b0 : oe_b ^ cf[6]);
        return {!en, src ^ cf[3]};
    endfunction

    initial begin
        logic [7:0] v;
        logic [3:0] c;
        logic [2:0] sel;
        logic [8:0] cf;
        logic       oe_b;
        logic [7:0][19:0] tv;
        v = 8'($urandom(32'h216A598D));
        wt(20);
        check("oe_n in reset", p_oe_n, 16'hFFFF);
        check("stored in reset", st_in, 16'h0);
        aresetn <= 1;
        @(posedge aclk);
        for (int k = 0; k < 9; k++) begin
            terms[0] <= tm[k];
            wr(ADDR_BLK_BASE, bc[k]);
            wt(3);
            check("block 0 outs", b_outs[3:0], be[k]);
        end
        for (int n = 0; n < 40; n++) begin
            v = 8'($urandom); c = 4'($urandom); sel = 3'($urandom);
            cf = 9'($urandom); oe_b = 1'($urandom);
            if (n < 3) cf[5:4] = 2'(n);
            else if (cf[5:4] == 2'h3) cf[5:4] = 2'h2;
            if (sel == c[3:1]) sel = sel + 3'h1;
            for (int b = 0; b < 8; b++) tv[b] = v[b] ? 20'h01000 : 20'h0;
            tv[sel][19] = oe_b;
            terms <= tv;
            ded <= 2'($urandom); b_en <= 16'($urandom);
            b_val <= 16'($urandom);
            wr(ADDR_GROUP, {29'h0, sel});
            wr(ADDR_CELL_BASE + 12'(c * 4), {23'h0, cf});
            wt(3);
            check("pin cell", {p_oe_n[c], p_out[c]},
                  cell_exp(c, cf, v[c[3:1]], oe_b));
            check("dedicated", ded_o, ded);
            check("global_in", g_in, lvl);
            rd_reg(ADDR_CELL_BASE + 12'(c * 4));
            check("cell cfg", rd, {23'h0, cf});
        end
        b_en <= 16'hFFFF;
        for (int m = 0; m < 4; m++) begin
            wr(ADDR_CELL_BASE, {23'h0, m[1], m[0], 3'h1, 4'h0});
            b_val <= 16'h0;
            clk_set(m[0], 1);
            clk_set(m[0], 0);
            check("stored low", st_in[0], 1'b0);
            b_val <= 16'h1;
            clk_set(!m[0], 1);
            check("other clock", st_in[0], 1'b0);
            clk_set(!m[0], 0);
            clk_set(m[0], 1);
            check("stored high", st_in[0], 1'b1);
            b_val <= 16'h0;
            wt(3);
            check("latch or hold", st_in[0], !m[1]);
            clk_set(m[0], 0);
        end
        rd_reg(12'hFFC);
        check("unmapped data", rd, 32'h0);
        check("unmapped resp", resp, RESP_SLVERR);
        wr(ADDR_PIN_IN, 32'h1);
        check("read-only write", resp, RESP_SLVERR);
        aresetn <= 0;
        wt(2);
        check("oe_n mid reset", p_oe_n, 16'hFFFF);
        check("out mid reset", {st_in, p_out}, 32'h0);
        aresetn <= 1;
        wt(1);
        rd_reg(ADDR_CELL_BASE);
        check("cell cfg reset", rd, CELL_CFG_RESET);
        results();
    end
endmodule
`default_nettype wire
